// ### dpc_regs.vh
// Timing counts and widths for the dual-port memory host controller
`ifndef DPC_REGS_VH
`define DPC_REGS_VH
`define DPC_AW 12
`define DPC_DW 9
`define DPC_CLK_PS 5000
// Least address set-up before the strobe falls (ns), counted as cycles
`define DPC_T_AS_NS 0
// Least write pulse width (ns)
`define DPC_T_WP_NS 30
// Least driver turn-off time after strobe falls (ns)
`define DPC_T_WZ_NS 15
// Least data set-up before end of write (ns)
`define DPC_T_DW_NS 25
// Write recovery after strobe rises (ns)
`define DPC_T_WR_NS 2
// Address access time for a read (ns)
`define DPC_T_AA_NS 35
// Output enable access time (ns)
`define DPC_T_AOE_NS 20
// Output high-impedance time after enable rises (ns)
`define DPC_T_HZ_NS 15
// Cycles: least times round up, at least one
`define DPC_CYC(ns) ((((ns) * 1000 + `DPC_CLK_PS - 1) / `DPC_CLK_PS) < 1 ? 1 : \
  (((ns) * 1000 + `DPC_CLK_PS - 1) / `DPC_CLK_PS))
`endif

// ### dpc_host.v
// Host-side controller driving one port of the asynchronous dual-port memory
`timescale 1ns/1ps
`include "dpc_regs.vh"

module dpc_host
(
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // User request side
  input wire req_valid,
  input wire req_write,
  input wire [`DPC_AW-1:0] req_addr,
  input wire [`DPC_DW-1:0] req_wdata,
  output wire req_ready,
  output reg rsp_valid_r,
  output reg [`DPC_DW-1:0] rsp_rdata_r,
  // Memory port pins
  output reg [`DPC_AW-1:0] port_address_r,
  output reg write_strobe_n_r,
  output reg output_enable_n_r,
  input wire [`DPC_DW-1:0] port_data_lines_in,
  output reg [`DPC_DW-1:0] port_data_lines_out_r,
  output reg port_data_lines_oe_n_r
);

  // Sequencer states
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_WSETUP = 3'd1;
  localparam [2:0] ST_WPULSE = 3'd2;
  localparam [2:0] ST_WREC = 3'd3;
  localparam [2:0] ST_RACC = 3'd4;
  localparam [2:0] ST_RHZ = 3'd5;

  // Timing figures in whole clock cycles, rounded up
  localparam integer N_AS = `DPC_CYC(`DPC_T_AS_NS);
  localparam integer N_WZ = `DPC_CYC(`DPC_T_WZ_NS);
  localparam integer N_WP = `DPC_CYC(`DPC_T_WP_NS);
  localparam integer N_DW = `DPC_CYC(`DPC_T_DW_NS);
  localparam integer N_WR = `DPC_CYC(`DPC_T_WR_NS);
  localparam integer N_AA = `DPC_CYC(`DPC_T_AA_NS);
  localparam integer N_HZ = `DPC_CYC(`DPC_T_HZ_NS);
  localparam integer N_WZDW = N_WZ + N_DW;
  // Strobe low for larger of pulse width or turn-off plus set-up
  localparam integer N_WPULSE = (N_WP > N_WZDW) ? N_WP : N_WZDW;
  // Read capture waits access time plus sampler depth
  localparam integer N_RACC = N_AA + 3;

  // Counter load values, cut to the counter width
  localparam [7:0] C_AS = N_AS[7:0];
  localparam [7:0] C_WZ = N_WZ[7:0];
  localparam [7:0] C_WP = N_WPULSE[7:0];
  localparam [7:0] C_WR = N_WR[7:0];
  localparam [7:0] C_AA = N_RACC[7:0];
  localparam [7:0] C_HZ = N_HZ[7:0];
  // Pulse count at which the host starts driving write data
  localparam [7:0] C_DRIVE = C_WP - C_WZ + 8'd1;

  // Sequencer state and wait counter
  reg [2:0] state_r;
  reg [7:0] cnt_r;
  // Sampler stages for the data pins
  reg [`DPC_DW-1:0] sync1_r;
  reg [`DPC_DW-1:0] sync2_r;
  reg [`DPC_DW-1:0] sync3_r;

  // Pins read back once the last two sampler stages agree
  wire read_settled;
  assign read_settled = (sync2_r == sync3_r);

  // True on the last cycle of a counted wait
  function last_tick;
    input [7:0] count;
    begin
      last_tick = (count <= 8'd1);
    end
  endfunction

  // Accepts a request only while idle
  assign req_ready = (state_r == ST_IDLE);

  // Three-stage sampler for read data from the pins
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_r <= 9'h000;
      sync2_r <= 9'h000;
      sync3_r <= 9'h000;
    end
    else
    begin
      sync1_r <= port_data_lines_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Port sequencer: one request at a time, pins from flip-flops
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // Pins idle: strobe and enables high, bus released
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      port_address_r <= 12'h000;
      write_strobe_n_r <= 1'b1;
      output_enable_n_r <= 1'b1;
      port_data_lines_out_r <= 9'h000;
      port_data_lines_oe_n_r <= 1'b1;
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= 9'h000;
    end
    else
    begin
      // Response strobe lasts a single cycle
      rsp_valid_r <= 1'b0;
      case (state_r)
        // Wait for a request; pins are quiet here
        ST_IDLE:
        begin
          if (req_valid)
          begin
            // Address moves only while the strobe is high
            port_address_r <= req_addr;
            cnt_r <= req_write ? C_AS : C_AA;
            // One write at a time; same-word writes across ports are the user's to avoid
            port_data_lines_out_r <= req_wdata;
            // Enable stays high on writes so device drivers stay off
            output_enable_n_r <= req_write;
            state_r <= req_write ? ST_WSETUP : ST_RACC;
          end
        end
        // Address set-up before the strobe falls
        ST_WSETUP:
        begin
          if (last_tick(cnt_r))
          begin
            // Strobe falls; the device starts its store
            write_strobe_n_r <= 1'b0;
            cnt_r <= C_WP;
            state_r <= ST_WPULSE;
          end
          else
            cnt_r <= cnt_r - 8'd1;
        end
        // Strobe low; data joins the bus after turn-off time
        ST_WPULSE:
        begin
          // Drive data once device drivers have turned off
          if (cnt_r == C_DRIVE)
            port_data_lines_oe_n_r <= 1'b0;
          if (last_tick(cnt_r))
          begin
            // Data held across strobe rise, latched there
            write_strobe_n_r <= 1'b1;
            cnt_r <= C_WR;
            state_r <= ST_WREC;
          end
          else
            cnt_r <= cnt_r - 8'd1;
        end
        // Recovery: data held one more cycle past the strobe rise
        ST_WREC:
        begin
          if (last_tick(cnt_r))
          begin
            // Release the data pins and take the next request
            port_data_lines_oe_n_r <= 1'b1;
            state_r <= ST_IDLE;
          end
          else
            cnt_r <= cnt_r - 8'd1;
        end
        // Read: wait for access time and sampler depth
        ST_RACC:
        begin
          // Take the word at the last tick of the count if the sampler has settled,
          // and otherwise one cycle later
          if (last_tick(cnt_r) && (read_settled || cnt_r == 8'h00))
          begin
            rsp_rdata_r <= sync3_r;
            rsp_valid_r <= 1'b1;
            output_enable_n_r <= 1'b1;
            cnt_r <= C_HZ;
            state_r <= ST_RHZ;
          end
          else
            cnt_r <= cnt_r - 8'd1;
        end
        // Let device drivers float before the next request
        ST_RHZ:
        begin
          // Count out the float time
          if (last_tick(cnt_r))
            state_r <= ST_IDLE;
          else
            cnt_r <= cnt_r - 8'd1;
        end
        // Unused codes fall back to idle
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // dpc_host

// ### dpc_mem_model.sv
// Behavioural model of one memory port
`timescale 1ns/1ps
`include "dpc_regs.vh"
module dpc_mem_model
(
  // Pins
  input wire [11:0] addr,
  input wire we_n,
  input wire oe_n,
  input wire [8:0] din,
  output wire [8:0] dout
);
  reg [8:0] mem [0:4095];
  wire [13:0] ctl_now;
  wire [13:0] ctl_late;
  wire rd_valid;
  // Store at strobe rise
  always @(posedge we_n) mem[addr] <= din;
  // Controls must stand unchanged for a full access time
  assign ctl_now = {addr, we_n, oe_n};
  assign #(`DPC_T_AA_NS) ctl_late = ctl_now;
  assign rd_valid = (ctl_late === ctl_now) && we_n && !oe_n;
  // Drive on a settled read, else inverted
  assign dout = rd_valid ? mem[addr] : ~mem[addr];
endmodule // dpc_mem_model

// ### dpc_host_assertions.sv
// Checker of host port timing
`timescale 1ns/1ps
module dpc_host_chk
(
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // Requests
  input wire req_valid,
  input wire req_write,
  input wire req_ready,
  input wire rsp_valid_r,
  // Pins
  input wire [11:0] port_address_r,
  input wire write_strobe_n_r,
  input wire output_enable_n_r,
  input wire port_data_lines_oe_n_r
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  chk_addr_hold:
    assert property (!write_strobe_n_r |-> $stable(port_address_r)) else $error("addr");
  chk_pulse_width:
    assert property ($fell(write_strobe_n_r) |-> !write_strobe_n_r [*8]) else $error("pulse");
  chk_turn_off:
    assert property ($fell(write_strobe_n_r) |-> port_data_lines_oe_n_r [*3]) else $error("drive");
  chk_no_clash:
    assert property (!port_data_lines_oe_n_r |-> output_enable_n_r) else $error("clash");
  chk_data_setup:
    assert property ($rose(write_strobe_n_r) |-> !$past(port_data_lines_oe_n_r, 5)) else $error("setup");
  chk_write_start:
    assert property (req_valid && req_ready && req_write |-> ##2 $fell(write_strobe_n_r)) else $error("wr");
  chk_read_start:
    assert property (req_valid && req_ready && !req_write |=> !output_enable_n_r) else $error("rd");
  chk_read_done:
    assert property (req_valid && req_ready && !req_write |-> ##[11:13] rsp_valid_r) else $error("rsp");
  // Main scenarios
  cover property ($rose(write_strobe_n_r));
  cover property (rsp_valid_r);
  cover property (req_valid && !req_ready);
endmodule // dpc_host_chk

// ### dpc_host_tb_top.sv
// Testbench of the host controller
`timescale 1ns/1ps
module dpc_host_tb_top;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg req_valid = 1'b0;
  reg req_write = 1'b0;
  reg [11:0] req_addr = 12'h000;
  reg [8:0] req_wdata = 9'h000;
  reg [8:0] q;
  reg [8:0] pulses;
  wire req_ready, rsp_valid_r, write_strobe_n_r, output_enable_n_r, port_data_lines_oe_n_r;
  wire [8:0] rsp_rdata_r, port_data_lines_out_r, mem_q;
  wire [11:0] port_address_r;
  // Resolved data wire
  wire [8:0] port_data_lines_in = port_data_lines_oe_n_r ? mem_q : port_data_lines_out_r;
  integer err_count = 0;
  integer checks = 0;
  always #2.5 clk = ~clk;
  dpc_host dpc_host_i (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid_r(rsp_valid_r),
    .rsp_rdata_r(rsp_rdata_r), .port_address_r(port_address_r), .write_strobe_n_r(write_strobe_n_r),
    .output_enable_n_r(output_enable_n_r), .port_data_lines_in(port_data_lines_in),
    .port_data_lines_out_r(port_data_lines_out_r), .port_data_lines_oe_n_r(port_data_lines_oe_n_r));
  dpc_mem_model dpc_mem_model_i (.addr(port_address_r), .we_n(write_strobe_n_r),
    .oe_n(output_enable_n_r), .din(port_data_lines_in), .dout(mem_q));
  // Compare a word
  task cmp9(input [8:0] got, input [8:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("MISMATCH %0t got %h", $time, got);
      end
    end
  endtask
  // Compare an address
  task cmp12(input [11:0] got, input [11:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("MISMATCH %0t addr %h", $time, got);
      end
    end
  endtask
  // One request, back to idle
  task xfer(input w, input [11:0] a, input [8:0] d);
    integer n;
    begin
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      @(posedge clk);
      req_valid <= 1'b0;
      q = 'x;
      pulses = 9'h000;
      n = 0;
      while (n < 40 && (n == 0 || req_ready !== 1'b1))
      begin
        @(negedge clk);
        if (rsp_valid_r === 1'b1)
        begin
          q = rsp_rdata_r;
          pulses = pulses + 9'h001;
        end
        n = n + 1;
      end
      if (req_ready !== 1'b1)
      begin
        err_count = err_count + 1;
        $display("MISMATCH %0t request never finished", $time);
      end
    end
  endtask
  task test_rw;
    begin
      cmp9({6'h00, write_strobe_n_r, output_enable_n_r, port_data_lines_oe_n_r}, 9'h007);
      xfer(1'b1, 12'h000, 9'h1a5);
      cmp9(pulses, 9'h000);
      xfer(1'b0, 12'h000, 9'h000);
      cmp9(q, 9'h1a5);
      cmp9(pulses, 9'h001);
      $display("test_rw done");
    end
  endtask
  task test_ends;
    begin
      xfer(1'b1, 12'hfff, 9'h1ff);
      xfer(1'b1, 12'h001, 9'h000);
      xfer(1'b0, 12'hfff, 9'h000);
      cmp9(q, 9'h1ff);
      cmp12(port_address_r, 12'hfff);
      xfer(1'b0, 12'h001, 9'h1ff);
      cmp9(q, 9'h000);
      $display("test_ends done");
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    test_rw;
    test_ends;
    end_of_test;
  end
  // Watchdog
  initial
  begin
    #5000;
    err_count = err_count + 1;
    end_of_test;
  end
endmodule // dpc_host_tb_top
bind dpc_host dpc_host_chk dpc_host_chk_i (.clk(clk), .reset_n(reset_n), .req_valid(req_valid),
  .req_write(req_write), .req_ready(req_ready), .rsp_valid_r(rsp_valid_r), .port_address_r(port_address_r),
  .write_strobe_n_r(write_strobe_n_r), .output_enable_n_r(output_enable_n_r),
  .port_data_lines_oe_n_r(port_data_lines_oe_n_r));
